// ---- common/sbb_regs.vh ----
// Register map, field positions and timing constants of the serial byte block
`ifndef SBB_REGS_VH
`define SBB_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define SBB_CTRL_ADDR      8'hC0
`define SBB_DATA_ADDR      8'hC2

// ****************************************
// Control register field positions
// ****************************************
`define SBB_BIT_MASTER     7
`define SBB_BIT_TXMODE     6
`define SBB_BIT_STA        5
`define SBB_BIT_STOP_REQ   4
`define SBB_BIT_ACK_REQ    3
`define SBB_BIT_ARBLOST    2
`define SBB_BIT_ACK        1
`define SBB_BIT_SI         0

// ****************************************
// Reset values
// ****************************************
`define SBB_DATA_RESET     8'h00
`define SBB_CTRL_RESET     8'h00

// ****************************************
// Timing
// ****************************************
`define SBB_CLK_NS         100
`define SBB_SCL_HALF_NS    500
`define SBB_SCL_HALF_CYC   ((`SBB_SCL_HALF_NS + `SBB_CLK_NS - 1) / `SBB_CLK_NS)

`endif

// ---- dv/sbb_core_props.sv ----
// Port checker of the serial byte core
`timescale 1ns/1ps
`include "sbb_regs.vh"
module sbb_core_props #(
  parameter SCL_HALF = 5
) (
  // Clock and reset
  input wire       clk_i,
  input wire       rst_i,
  // Register port
  input wire [7:0] sfr_addr_i,
  input wire       sfr_wr_i,
  input wire [7:0] sfr_wdata_i,
  input wire [7:0] sfr_rdata_o,
  input wire       slave_inhibit_i,
  // Bus pins
  input wire       scl_i,
  input wire       scl_o,
  input wire       scl_oe_o,
  input wire       sda_i,
  input wire       sda_o,
  input wire       sda_oe_o,
  // Receive stream
  input wire [7:0] rx_data_o,
  input wire       rx_valid_o,
  input wire       rx_ready_i
);
  // Two ticks of the master clock plus sync slack
  localparam int START_MAX = 2 * SCL_HALF + 2;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_open_drain;
    scl_o == 1'b0 && sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");

  property p_rst_idle;
    $fell(rst_i) |-> !scl_oe_o && !sda_oe_o && !rx_valid_o && sfr_rdata_o == 8'h00;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");

  property p_unmapped;
    sfr_addr_i != `SBB_CTRL_ADDR && sfr_addr_i != `SBB_DATA_ADDR |=> sfr_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_data_wr;
    sfr_wr_i && sfr_addr_i == `SBB_DATA_ADDR ##1 sfr_addr_i == `SBB_DATA_ADDR
      |=> sfr_rdata_o == $past(sfr_wdata_i, 2);
  endproperty
  a_data_wr: assert property (p_data_wr) else $error("data write lost");

  property p_rx_hold;
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("stream head changed");

  property p_start;
    $rose(sda_oe_o) && scl_i |-> ##[1:START_MAX] scl_oe_o;
  endproperty
  a_start: assert property (p_start) else $error("no clock after start");

  property p_stop;
    $fell(sda_oe_o) && scl_i |=> !scl_oe_o [*4];
  endproperty
  a_stop: assert property (p_stop) else $error("clock pulled after stop");

  property p_frozen;
    (sfr_addr_i == `SBB_DATA_ADDR && !sfr_wr_i && scl_oe_o) [*2] |=> $stable(sfr_rdata_o);
  endproperty
  a_frozen: assert property (p_frozen) else $error("data moved in stall");
endmodule
// sbb_core_props

bind sbb_core sbb_core_props #(.SCL_HALF(SCL_HALF)) i_props (
  .clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .slave_inhibit_i(slave_inhibit_i),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i)
);

// ---- dv/sbb_slave_model.sv ----
// Behavioural slave device on the two-wire bus
`timescale 1ns/1ps
module sbb_slave_model (
  // Bus wires
  input  wire scl_i,
  input  wire sda_i,
  output reg  sda_low_o
);
  logic [7:0] got_q[$];
  logic [7:0] tx_q[$];
  logic       ack_q[$];
  logic [7:0] sh;
  logic [7:0] b;
  integer     i;

  initial sda_low_o = 1'b0;

  // first bit taken lands in the top
  task automatic get_byte();
    repeat (8) @(posedge scl_i) sh = {sh[6:0], sda_i};
    got_q.push_back(sh);
  endtask

  task automatic give_ack();
    @(negedge scl_i) sda_low_o = 1'b1;
    @(negedge scl_i) sda_low_o = 1'b0;
  endtask

  // ********
  // Frames
  // ********
  // STOP ends the frame
  always @(posedge sda_i)
    if (scl_i === 1'b1)
    begin
      disable frame;
      sda_low_o = 1'b0;
    end

  always @(negedge sda_i)
    if (scl_i === 1'b1)
    begin : frame
      get_byte();
      give_ack();
      if (sh[0] === 1'b1)
        forever
        begin
          b = tx_q.pop_front();
          for (i = 7; i >= 0; i--)
          begin
            if (i < 7) @(negedge scl_i);
            sda_low_o = ~b[i];
          end
          @(negedge scl_i) sda_low_o = 1'b0;
          @(posedge scl_i) ack_q.push_back(~sda_i);
          @(negedge scl_i);
          // Released after NACK, waiting for STOP
          wait (ack_q[$] === 1'b1);
        end
      else
        forever
        begin
          get_byte();
          give_ack();
        end
    end
endmodule
// sbb_slave_model

// ---- dv/tb_top.sv ----
// Self-checking bench of the serial byte core
`timescale 1ns/1ps
`include "sbb_regs.vh"
module tb_top;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic       sfr_wr_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic       rx_ready_i = 1'b0;
  wire  [7:0] sfr_rdata_o;
  wire  [7:0] rx_data_o;
  wire        rx_valid_o;
  wire        scl_oe_o;
  wire        sda_oe_o;
  wire        sda_low;
  // Pull-ups on both wires
  wire        scl = ~scl_oe_o;
  wire        sda = ~(sda_oe_o | sda_low);
  integer     num_errors = 0;
  integer     tests_run = 0;
  integer     seed = 76968;
  integer     i;
  logic [7:0] d;
  logic [7:0] ctl;
  logic [7:0] exp_q[$];

  always #50 clk_i = ~clk_i;

  sbb_core #(.SCL_HALF(4), .FIFO_DEPTH(32), .FIFO_AW(5)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .slave_inhibit_i(1'b0),
    .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i)
  );

  sbb_slave_model i_slv (.scl_i(scl), .sda_i(sda), .sda_low_o(sda_low));

  // ********
  // Helpers
  // ********
  function automatic logic [7:0] rnd8();
    integer r;
    r = $random(seed);
    return r[7:0];
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= v;
    sfr_wr_i <= 1'b1;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    sfr_addr_i <= a;
    @(posedge clk_i);
    @(posedge clk_i);
    #1 v = sfr_rdata_o;
  endtask

  // Polls the control register, bounded
  task automatic wait_bit(input int b, input logic v);
    ctl = ~{8{v}};
    for (int n = 0; n < 3000 && ctl[b] !== v; n++) rd(`SBB_CTRL_ADDR, ctl);
    chk("ctrl bit", {7'h00, v}, {7'h00, ctl[b]});
  endtask

  task automatic stop_test();
    if (num_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #3_000_000;
    num_errors++;
    stop_test();
  end

  // ********
  // Sequence
  // ********
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SBB_DATA_ADDR, d);
    chk("data reset", `SBB_DATA_RESET, d);
    rd(`SBB_CTRL_ADDR, d);
    chk("ctrl reset", `SBB_CTRL_RESET, d);
    rd(8'h5A, d);
    chk("unmapped", 8'h00, d);
    // registers touched only with flag set, apart from the START requests
    wr(`SBB_CTRL_ADDR, 8'h20);
    wait_bit(`SBB_BIT_SI, 1'b1);
    chk("master tx", 8'hC0, ctl & 8'hC0);
    for (i = 0; i < 3; i++)
    begin
      d = rnd8() & {7'h7F, i != 0};
      exp_q.push_back(d);
      wr(`SBB_DATA_ADDR, d);
      wr(`SBB_CTRL_ADDR, 8'h00);
      wait_bit(`SBB_BIT_SI, 1'b1);
      chk("ack in", 8'hC2, ctl & 8'hC2);
      rd(`SBB_DATA_ADDR, ctl);
      chk("echo", d, ctl);
    end
    wr(`SBB_CTRL_ADDR, 8'h10);
    wait_bit(`SBB_BIT_MASTER, 1'b0);
    chk("stop done", 8'h00, ctl & 8'hD1);
    for (i = 0; i < 3; i++)
      chk("wire byte", exp_q[i], i_slv.got_q[i]);
    exp_q.delete();
    i_slv.got_q.delete();
    for (i = 0; i < 32; i++)
    begin
      exp_q.push_back(rnd8());
      i_slv.tx_q.push_back(exp_q[i]);
    end
    wr(`SBB_CTRL_ADDR, 8'h20);
    wait_bit(`SBB_BIT_SI, 1'b1);
    d = rnd8() | 8'h01;
    wr(`SBB_DATA_ADDR, d);
    wr(`SBB_CTRL_ADDR, 8'h00);
    wait_bit(`SBB_BIT_SI, 1'b1);
    chk("addr wire", d, i_slv.got_q[0]);
    // Flag cleared without a data write
    wr(`SBB_CTRL_ADDR, 8'h00);
    for (i = 0; i < 32; i++)
    begin
      wait_bit(`SBB_BIT_SI, 1'b1);
      chk("rx mode", 8'h88, ctl & 8'hC8);
      rd(`SBB_DATA_ADDR, d);
      chk("rx byte", exp_q[i], d);
      wr(`SBB_CTRL_ADDR, i == 31 ? 8'h10 : 8'h02);
    end
    wait_bit(`SBB_BIT_MASTER, 1'b0);
    for (i = 0; i < 32; i++)
      chk("ack out", {7'h00, i != 31}, {7'h00, i_slv.ack_q[i]});
    // Drain with random stalls
    for (i = 0; i < 32; i++)
    begin
      repeat (rnd8() & 8'h03) @(posedge clk_i);
      #1;
      chk("rx valid", 8'h01, {7'h00, rx_valid_o});
      chk("rx data", exp_q[i], rx_data_o);
      @(posedge clk_i);
      rx_ready_i <= 1'b1;
      @(posedge clk_i);
      rx_ready_i <= 1'b0;
    end
    #1;
    chk("rx empty", 8'h00, {7'h00, rx_valid_o});
    stop_test();
  end
endmodule
// tb_top

// ---- rtl/sbb_core.v ----
// Serial byte shift register, transfer modes and receive FIFO of the two-wire bus
//
// Operation
// - Data byte frozen while interrupt flag set
// - Bytes shifted out most significant first
// - First received bit lands in MSB
// - Transmit shifts bus value back in
// - Lost arbitration becomes slave receiver, byte kept
// - Master from START until STOP or loss
// - Receiver flags before ACK, transmitter after
// - Master write: START, address, acked data bytes
// - Master transfer ends by stop request, STOP
// - Unwritten byte after master send: receive
// - Master read: START, address, clock slave data
// - Master receiver sets ack request, flags
// - Ack bit one gives ACK, zero NACK
// - Data write as master receiver: transmit
// - Uninhibited address write enters slave receive
// - NACKed address silences slave until START
// - Slave modes end on STOP, on START or on a NACKed address
// - Data write as slave receiver: transmit
// - Write after slave NACK flags error
// - Unwritten byte after slave send: receive
// - Flag set holds SCL low
// - Stop request self-clears once STOP sent
`timescale 1ns/1ps
`include "sbb_regs.vh"

// ****************************************
// Receive FIFO
// ****************************************
module sbb_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // Fill side
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  // Drain side
  output reg  [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            empty;
  wire            full;
  wire            push;
  wire            pop;

  assign empty       = (wr_ptr == rd_ptr);
  assign full        = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign push        = in_valid_i & ~full;
  assign pop         = out_ready_i & ~empty;

  always @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always @*
  begin
    out_data_o = mem[rd_ptr[AW-1:0]];
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // sbb_fifo

// ****************************************
// Shift and mode engine
// ****************************************
module sbb_core #(
  parameter SCL_HALF   = `SBB_SCL_HALF_CYC,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW    = 5
) (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // Special function register port
  input  wire [7:0] sfr_addr_i,
  input  wire       sfr_wr_i,
  input  wire [7:0] sfr_wdata_i,
  output reg  [7:0] sfr_rdata_o,
  // Loose control
  input  wire       slave_inhibit_i,
  // Bus pins
  input  wire       scl_i,
  output wire       scl_o,
  output wire       scl_oe_o,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_o,
  // Received byte stream
  output wire [7:0] rx_data_o,
  output wire       rx_valid_o,
  input  wire       rx_ready_i
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_BITS  = 3'd2;
  localparam ST_STOP1 = 3'd3;
  localparam ST_STOP2 = 3'd4;
  localparam ST_STOP3 = 3'd5;

  reg  [7:0] serial_byte_buffer;
  reg        master;
  reg        txmode;
  reg        sta;
  reg        stop_request_bit;
  reg        ack_request_flag;
  reg        arblost;
  reg        ack;
  reg        si;
  reg  [2:0] st;
  reg  [3:0] bitcnt;
  reg  [7:0] divcnt;
  reg        tick;
  reg        mclk_low;
  reg        sda_low;
  reg        byte_rx;
  reg        loaded;
  reg        active;
  reg        ignore;
  reg        addr_phase;
  reg        busy;
  reg        pend_push;
  reg  [1:0] scl_sync;
  reg  [1:0] sda_sync;
  reg        scl_q;
  reg        sda_q;
  wire       scl_s;
  wire       sda_s;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;
  wire       part;
  wire       fifo_ready;
  wire       wr_ctrl;
  wire       wr_data;
  wire       si_clear;
  wire [7:0] ctrl_word;

  // Low drive on SDA for a given bit slot
  function drive_low;
    input [3:0] cnt;
    input       tx;
    input       d7;
    input       ackb;
    begin
      if (cnt < 4'd8)
      begin
        drive_low = tx & ~d7;
      end
      else
      begin
        drive_low = ~tx & ackb;
      end
    end
  endfunction

  // ****************************************
  // Pin synchronisers and bus events
  // ****************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  assign scl_s     = scl_sync[1];
  assign sda_s     = sda_sync[1];
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;
  assign part      = master | active;

  // ****************************************
  // Bus clock divider
  // ****************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      divcnt <= 8'h00;
      tick   <= 1'b0;
    end
    else if (divcnt == SCL_HALF[7:0] - 8'h01)
    begin
      divcnt <= 8'h00;
      tick   <= 1'b1;
    end
    else
    begin
      divcnt <= divcnt + 8'h01;
      tick   <= 1'b0;
    end
  end

  // ****************************************
  // Register access
  // ****************************************
  assign wr_ctrl   = sfr_wr_i && (sfr_addr_i == `SBB_CTRL_ADDR);
  assign wr_data   = sfr_wr_i && (sfr_addr_i == `SBB_DATA_ADDR);
  assign si_clear  = wr_ctrl & ~sfr_wdata_i[`SBB_BIT_SI] & si;
  assign ctrl_word = {master, txmode, sta, stop_request_bit,
                      ack_request_flag, arblost, ack, si};

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sfr_rdata_o <= 8'h00;
    end
    else if (sfr_addr_i == `SBB_DATA_ADDR)
    begin
      sfr_rdata_o <= serial_byte_buffer;
    end
    else if (sfr_addr_i == `SBB_CTRL_ADDR)
    begin
      sfr_rdata_o <= ctrl_word;
    end
    else
    begin
      sfr_rdata_o <= 8'h00;
    end
  end

  // ****************************************
  // Byte engine
  // ****************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      serial_byte_buffer <= `SBB_DATA_RESET;
      {master, txmode, sta, stop_request_bit} <= 4'h0;
      {ack_request_flag, arblost, ack, si}    <= 4'h0;
      st         <= ST_IDLE;
      bitcnt     <= 4'h0;
      mclk_low   <= 1'b0;
      sda_low    <= 1'b0;
      byte_rx    <= 1'b0;
      loaded     <= 1'b0;
      active     <= 1'b0;
      ignore     <= 1'b0;
      addr_phase <= 1'b0;
      busy       <= 1'b0;
      pend_push  <= 1'b0;
    end
    else
    begin
      if (pend_push & fifo_ready)
      begin
        pend_push <= 1'b0;
      end
      if (wr_ctrl)
      begin
        sta              <= sfr_wdata_i[`SBB_BIT_STA];
        stop_request_bit <= sfr_wdata_i[`SBB_BIT_STOP_REQ];
        ack              <= sfr_wdata_i[`SBB_BIT_ACK];
      end
      if (wr_data)
      begin
        serial_byte_buffer <= sfr_wdata_i;
        loaded             <= si;
        if (si & txmode & ~master & ~ack)
        begin
          arblost <= 1'b1;
        end
      end
      if (si_clear)
      begin
        si     <= 1'b0;
        loaded <= 1'b0;
        if (master & sfr_wdata_i[`SBB_BIT_STOP_REQ] & (bitcnt == 4'h0))
        begin
          st      <= ST_STOP1;
          sda_low <= 1'b1;
        end
        else
        begin
          txmode  <= loaded | wr_data;
          sda_low <= part & drive_low(bitcnt, (bitcnt == 4'h8) ? 1'b0 : (loaded | wr_data),
                                      serial_byte_buffer[7], sfr_wdata_i[`SBB_BIT_ACK]);
        end
      end
      if (start_det)
      begin
        busy       <= 1'b1;
        bitcnt     <= 4'h0;
        addr_phase <= 1'b1;
        if (~master)
        begin
          active <= 1'b0;
          ignore <= 1'b0;
          txmode <= 1'b0;
        end
      end
      if (stop_det)
      begin
        busy <= 1'b0;
        if (active)
        begin
          active           <= 1'b0;
          txmode           <= 1'b0;
          stop_request_bit <= 1'b1;
        end
      end
      if (scl_rise & ~si & ~ignore)
      begin
        if (bitcnt < 4'h8)
        begin
          serial_byte_buffer <= {serial_byte_buffer[6:0], sda_s};
          if (master & txmode & ~sda_low & ~sda_s)
          begin
            master   <= 1'b0;
            txmode   <= 1'b0;
            arblost  <= 1'b1;
            active   <= 1'b1;
            st       <= ST_IDLE;
            mclk_low <= 1'b0;
          end
        end
        else if (~byte_rx)
        begin
          ack <= ~sda_s;
        end
      end
      if (scl_fall & ~si & ~ignore & (busy | master))
      begin
        if (bitcnt == 4'h7)
        begin
          bitcnt  <= 4'h8;
          byte_rx <= ~txmode;
          sda_low <= 1'b0;
          if (~txmode)
          begin
            pend_push <= ~addr_phase | master;
            if (part | (addr_phase & ~slave_inhibit_i))
            begin
              ack_request_flag <= 1'b1;
              si               <= 1'b1;
              active           <= ~master;
              sta              <= addr_phase & ~master;
            end
            else
            begin
              ignore <= 1'b1;
            end
          end
        end
        else if (bitcnt == 4'h8)
        begin
          bitcnt     <= 4'h0;
          addr_phase <= 1'b0;
          if (byte_rx)
          begin
            ack_request_flag <= 1'b0;
            if (addr_phase & ~master & ~ack)
            begin
              ignore  <= 1'b1;
              active  <= 1'b0;
              sda_low <= 1'b0;
            end
            else if (master & stop_request_bit)
            begin
              st      <= ST_STOP1;
              sda_low <= 1'b1;
            end
            else
            begin
              sda_low <= part & drive_low(4'h0, txmode, serial_byte_buffer[7], ack);
            end
          end
          else
          begin
            si      <= part;
            sda_low <= 1'b0;
          end
        end
        else
        begin
          bitcnt  <= bitcnt + 4'h1;
          sda_low <= part & txmode & ~serial_byte_buffer[7];
        end
      end
      // Master clock and framing
      case (st)
        ST_IDLE:
        begin
          if (tick & sta & ~busy & ~master & ~si)
          begin
            st      <= ST_START;
            sda_low <= 1'b1;
          end
        end
        ST_START:
        begin
          if (tick)
          begin
            st       <= ST_BITS;
            mclk_low <= 1'b1;
            master   <= 1'b1;
            txmode   <= 1'b1;
            si       <= 1'b1;
          end
        end
        ST_BITS:
        begin
          if (tick & ~si & ~pend_push)
          begin
            if (mclk_low)
            begin
              mclk_low <= 1'b0;
            end
            else if (scl_s)
            begin
              mclk_low <= 1'b1;
            end
          end
        end
        ST_STOP1:
        begin
          if (tick)
          begin
            st       <= ST_STOP2;
            mclk_low <= 1'b0;
          end
        end
        ST_STOP2:
        begin
          if (tick & scl_s)
          begin
            st      <= ST_STOP3;
            sda_low <= 1'b0;
          end
        end
        ST_STOP3:
        begin
          if (tick)
          begin
            st               <= ST_IDLE;
            master           <= 1'b0;
            txmode           <= 1'b0;
            stop_request_bit <= 1'b0;
          end
        end
        default:
        begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Open drain: output level is always low, enable does the work
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = mclk_low | (part & (si | pend_push));
  assign sda_oe_o = sda_low;

  // ****************************************
  // Receive stream buffer
  // ****************************************
  // A full FIFO stretches SCL rather than dropping a byte
  sbb_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   (serial_byte_buffer),
    .in_valid_i  (pend_push),
    .in_ready_o  (fifo_ready),
    .out_data_o  (rx_data_o),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i)
  );
endmodule // sbb_core
